// *** verilog/srs_stop_reaction.sv ***
`timescale 1ns/1ps

// Contract
// - Speed in rpm is speed times num over den.
// - Signed 32-bit num, den preset one; count two.
// - Quick-stop code signed 16-bit, preset two.
// - Codes 0/1/2 stop, then switch-on disabled.
// - Codes 5/6 brake, then hold quick stop energized.
// - Shutdown code 0 immediate, 1 slow ramp; preset one.
// - Disable code 0 immediate, 1 slow ramp; preset one.
// - Halt bit 8: code 1 slow, 2 quick ramp.
// - Velocity mode quick ramp from quick-stop object.
module srs_stop_reaction (
   input wire logic clock_i,                          // Clock, 250 MHz.
   input wire logic rstn_i,                           // Async reset, low.
   input wire srs_pkg::srs_obj_req_type obj_req_i,    // Object access.
   output srs_pkg::srs_obj_rsp_type obj_rsp_o,        // Object answer.
   input wire logic quick_stop_evt_i,                 // Enter quick stop.
   input wire logic shutdown_evt_i,                   // Op enabled to RTSO.
   input wire logic disable_evt_i,                    // Op enabled to SO.
   input wire logic [15:0] control_word_i,            // Control word.
   input wire logic operation_enable_i,               // Return to op.
   input wire logic standstill_i,                     // Motor stopped.
   input wire logic velocity_mode_i,                  // Velocity mode on.
   input wire srs_pkg::srs_ramp_type slow_ramp_i,     // Mode slow ramp.
   input wire srs_pkg::srs_ramp_type mode_qs_ramp_i,  // Mode quick ramp.
   output srs_pkg::srs_act_type stop_action_o,        // Action applied.
   output srs_pkg::srs_ramp_type ramp_o,              // Ramp in use.
   output logic to_switch_on_disabled_o,              // State change.
   output logic quick_stop_hold_o,                    // Held, energized.
   output logic stop_busy_o,                          // Stop sequence on.
   input wire logic speed_valid_i,                    // Speed sample.
   input wire logic signed [31:0] speed_int_i,        // Internal speed.
   output logic signed [31:0] speed_rpm_o,            // Speed in rpm.
   output logic speed_rpm_valid_o,                    // Result pulse.
   output logic speed_busy_o,                         // Conversion on.
   output logic speed_div_zero_o                      // Denominator zero.
);

   // ************************************************************
   // Code decoding functions.
   // ************************************************************

   // Quick-stop codes map to a braking action.
   function automatic srs_pkg::srs_act_type qs_act(
      input logic signed [15:0] code
   );
      if (code == srs_pkg::CODE_IMMED) begin
         qs_act = srs_pkg::ACT_IMMED;
      end else if (code == srs_pkg::CODE_SLOW ||
                   code == srs_pkg::CODE_SLOW_HOLD) begin
         qs_act = srs_pkg::ACT_SLOW;
      end else begin
         qs_act = srs_pkg::ACT_QUICK;
      end
   endfunction

   // Shutdown and disable share one code set.
   function automatic srs_pkg::srs_act_type off_act(
      input logic signed [15:0] code
   );
      off_act = (code == srs_pkg::CODE_IMMED) ? srs_pkg::ACT_IMMED
                                              : srs_pkg::ACT_SLOW;
   endfunction

   // Valid shutdown or disable code.
   function automatic logic off_ok(input logic [15:0] code);
      off_ok = (code == srs_pkg::CODE_IMMED) ||
               (code == srs_pkg::CODE_SLOW);
   endfunction

   // ************************************************************
   // Stored objects.
   // ************************************************************
   logic signed [31:0] num_q;
   logic signed [31:0] den_q;
   logic signed [15:0] qs_code_q;
   logic signed [15:0] sd_code_q;
   logic signed [15:0] dis_code_q;
   logic signed [15:0] halt_code_q;
   srs_pkg::srs_ramp_type vqs_ramp_q;
   srs_pkg::srs_obj_rsp_type rsp_d;

   // Address decode.
   wire hit_scale = (obj_req_i.index == srs_pkg::IDX_SCALE);
   wire hit_vqs = (obj_req_i.index == srs_pkg::IDX_VQS);
   wire sub0 = (obj_req_i.sub == srs_pkg::SUB_COUNT);
   wire sub1 = (obj_req_i.sub == srs_pkg::SUB_1);
   wire sub2 = (obj_req_i.sub == srs_pkg::SUB_2);
   wire rec_hit = (hit_scale || hit_vqs) && (sub0 || sub1 || sub2);
   wire var_hit = sub0 &&
      (obj_req_i.index == srs_pkg::IDX_QS ||
       obj_req_i.index == srs_pkg::IDX_SD ||
       obj_req_i.index == srs_pkg::IDX_DIS ||
       obj_req_i.index == srs_pkg::IDX_HALT);
   wire mapped = rec_hit || var_hit;
   wire [15:0] wcode = obj_req_i.wdata[15:0];
   wire wr_on = obj_req_i.wr && !obj_req_i.rd;

   // Code validity.
   wire qs_ok = (wcode == srs_pkg::CODE_IMMED) ||
                (wcode == srs_pkg::CODE_SLOW) ||
                (wcode == srs_pkg::CODE_QUICK) ||
                (wcode == srs_pkg::CODE_SLOW_HOLD) ||
                (wcode == srs_pkg::CODE_QUICK_HOLD);
   wire halt_ok = (wcode == srs_pkg::CODE_SLOW) ||
                  (wcode == srs_pkg::CODE_QUICK);

   // Write strobes.
   wire wr_num = wr_on && hit_scale && sub1;
   wire wr_den = wr_on && hit_scale && sub2;
   wire wr_vds = wr_on && hit_vqs && sub1;
   wire wr_vdt = wr_on && hit_vqs && sub2;
   wire wr_qs_any = wr_on && sub0 && obj_req_i.index == srs_pkg::IDX_QS;
   wire wr_sd_any = wr_on && sub0 && obj_req_i.index == srs_pkg::IDX_SD;
   wire wr_dis_any = wr_on && sub0 &&
                     obj_req_i.index == srs_pkg::IDX_DIS;
   wire wr_halt_any = wr_on && sub0 &&
                      obj_req_i.index == srs_pkg::IDX_HALT;
   wire wr_qs = wr_qs_any && qs_ok;
   wire wr_sd = wr_sd_any && off_ok(wcode);
   wire wr_dis = wr_dis_any && off_ok(wcode);
   wire wr_halt = wr_halt_any && halt_ok;
   wire bad_code = (wr_qs_any || wr_sd_any || wr_dis_any || wr_halt_any) &&
                   !(wr_qs || wr_sd || wr_dis || wr_halt);
   wire wr_ro = wr_on && rec_hit && sub0;

   // Read data, zero extended.
   wire [31:0] rd_var =
      (obj_req_i.index == srs_pkg::IDX_QS) ? {16'h0000, qs_code_q} :
      (obj_req_i.index == srs_pkg::IDX_SD) ? {16'h0000, sd_code_q} :
      (obj_req_i.index == srs_pkg::IDX_DIS) ? {16'h0000, dis_code_q} :
      {16'h0000, halt_code_q};
   wire [31:0] rd_scale = sub0 ? {24'h000000, srs_pkg::COUNT_RST} :
                          sub1 ? num_q : den_q;
   wire [31:0] rd_vqs = sub0 ? {24'h000000, srs_pkg::COUNT_RST} :
                        sub1 ? vqs_ramp_q.dspeed :
                        {16'h0000, vqs_ramp_q.dtime};
   wire [31:0] rd_data = !mapped ? 32'h00000000 :
                         var_hit ? rd_var :
                         hit_scale ? rd_scale : rd_vqs;

   // Answer one cycle after any access.
   always_comb begin
      rsp_d.ack = obj_req_i.wr || obj_req_i.rd;
      rsp_d.err = (obj_req_i.wr || obj_req_i.rd) &&
                  (!mapped || (wr_on && (bad_code || wr_ro)) ||
                   (obj_req_i.wr && obj_req_i.rd));
      rsp_d.rdata = obj_req_i.rd ? rd_data : 32'h00000000;
   end

   // ************************************************************
   // Object storage.
   // ************************************************************
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         num_q <= srs_pkg::NUM_RST;
         den_q <= srs_pkg::DEN_RST;
         qs_code_q <= srs_pkg::QS_RST;
         sd_code_q <= srs_pkg::SD_RST;
         dis_code_q <= srs_pkg::DIS_RST;
         halt_code_q <= srs_pkg::HALT_RST;
         vqs_ramp_q <= {srs_pkg::VQS_DSPEED_RST, srs_pkg::VQS_DTIME_RST};
         obj_rsp_o <= '0;
      end else begin
         if (wr_num) num_q <= obj_req_i.wdata;
         if (wr_den) den_q <= obj_req_i.wdata;
         if (wr_qs) qs_code_q <= wcode;
         if (wr_sd) sd_code_q <= wcode;
         if (wr_dis) dis_code_q <= wcode;
         if (wr_halt) halt_code_q <= wcode;
         if (wr_vds) vqs_ramp_q.dspeed <= obj_req_i.wdata;
         if (wr_vdt) vqs_ramp_q.dtime <= wcode;
         obj_rsp_o <= rsp_d;
      end
   end

   // ************************************************************
   // Stop reaction sequencer.
   // ************************************************************
   srs_pkg::srs_state_type state_q;
   srs_pkg::srs_state_type state_d;
   srs_pkg::srs_act_type act_q;
   srs_pkg::srs_act_type act_d;
   srs_pkg::srs_ramp_type ramp_d;
   logic hold_q;
   logic hold_d;
   logic sod_d;

   wire halt_req = control_word_i[srs_pkg::HALT_BIT];
   wire qs_hold_code = (qs_code_q == srs_pkg::CODE_SLOW_HOLD) ||
                       (qs_code_q == srs_pkg::CODE_QUICK_HOLD);
   wire stop_done = (act_q == srs_pkg::ACT_IMMED) || standstill_i;

   // Priority: quick stop, disable, shutdown, halt.
   always_comb begin
      state_d = state_q;
      act_d = act_q;
      hold_d = hold_q;
      sod_d = 1'b0;
      case (state_q)
         srs_pkg::ST_RUN: begin
            if (quick_stop_evt_i) begin
               act_d = qs_act(qs_code_q);
               hold_d = qs_hold_code;
               state_d = srs_pkg::ST_STOP;
            end else if (disable_evt_i) begin
               act_d = off_act(dis_code_q);
               hold_d = 1'b0;
               state_d = srs_pkg::ST_STOP;
            end else if (shutdown_evt_i) begin
               act_d = off_act(sd_code_q);
               hold_d = 1'b0;
               state_d = srs_pkg::ST_STOP;
            end else if (halt_req) begin
               act_d = (halt_code_q == srs_pkg::CODE_QUICK) ?
                       srs_pkg::ACT_QUICK : srs_pkg::ACT_SLOW;
            end else begin
               act_d = srs_pkg::ACT_NONE;
            end
         end
         srs_pkg::ST_STOP: begin
            if (stop_done && hold_q) begin
               act_d = srs_pkg::ACT_NONE;
               state_d = srs_pkg::ST_HOLD;
            end else if (stop_done) begin
               act_d = srs_pkg::ACT_NONE;
               sod_d = 1'b1;
               state_d = srs_pkg::ST_RUN;
            end
         end
         srs_pkg::ST_HOLD: begin
            act_d = srs_pkg::ACT_NONE;
            if (operation_enable_i) begin
               hold_d = 1'b0;
               state_d = srs_pkg::ST_RUN;
            end
         end
         default: begin
            act_d = srs_pkg::ACT_NONE;
            hold_d = 1'b0;
            state_d = srs_pkg::ST_RUN;
         end
      endcase
   end

   // Ramp select per action.
   always_comb begin
      case (act_d)
         srs_pkg::ACT_QUICK:
            ramp_d = velocity_mode_i ? vqs_ramp_q
                                     : mode_qs_ramp_i;
         srs_pkg::ACT_SLOW: ramp_d = slow_ramp_i;
         default: ramp_d = '0;
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= srs_pkg::ST_RUN;
         act_q <= srs_pkg::ACT_NONE;
         hold_q <= 1'b0;
         stop_action_o <= srs_pkg::ACT_NONE;
         ramp_o <= '0;
         to_switch_on_disabled_o <= 1'b0;
         quick_stop_hold_o <= 1'b0;
         stop_busy_o <= 1'b0;
      end else begin
         state_q <= state_d;
         act_q <= act_d;
         hold_q <= hold_d;
         stop_action_o <= act_d;
         ramp_o <= ramp_d;
         to_switch_on_disabled_o <= sod_d;
         quick_stop_hold_o <= (state_d == srs_pkg::ST_HOLD);
         stop_busy_o <= (state_d == srs_pkg::ST_STOP);
      end
   end

   // ************************************************************
   // Speed conversion to revolutions per minute.
   // ************************************************************
   logic conv_q;
   logic div_done;
   logic div_dz;
   logic signed [63:0] div_quo;

   wire conv_start = speed_valid_i && !conv_q;
   wire signed [63:0] speed_prod = 64'(speed_int_i) * 64'(num_q);
   wire quo_hi = (div_quo > 64'sh000000007FFFFFFF);
   wire quo_lo = (div_quo < -64'sh0000000080000000);
   wire signed [31:0] quo_sat = quo_hi ? 32'sh7FFFFFFF :
                                quo_lo ? 32'sh80000000 :
                                div_quo[31:0];

   // Product over denominator.
   srs_div #(
      .NW(64),
      .DW(32)
   ) u_div (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .start_i(conv_start),
      .num_i(speed_prod),
      .den_i(den_q),
      .done_o(div_done),
      .dz_o(div_dz),
      .quo_o(div_quo)
   );

   // Saturated result capture.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         conv_q <= 1'b0;
         speed_rpm_o <= 32'sh00000000;
         speed_rpm_valid_o <= 1'b0;
         speed_busy_o <= 1'b0;
         speed_div_zero_o <= 1'b0;
      end else begin
         speed_rpm_valid_o <= div_done;
         if (conv_start) begin
            conv_q <= 1'b1;
            speed_busy_o <= 1'b1;
         end else if (div_done) begin
            conv_q <= 1'b0;
            speed_busy_o <= 1'b0;
         end
         if (div_done) begin
            speed_rpm_o <= quo_sat;
            speed_div_zero_o <= div_dz;
         end
      end
   end

endmodule

// *** verilog/srs_pkg.sv ***
package srs_pkg;

   // ************************************************************
   // Object indexes and subindexes.
   // ************************************************************
   localparam logic [15:0] IDX_SCALE = 16'h604C;
   localparam logic [15:0] IDX_VQS = 16'h604A;
   localparam logic [15:0] IDX_QS = 16'h605A;
   localparam logic [15:0] IDX_SD = 16'h605B;
   localparam logic [15:0] IDX_DIS = 16'h605C;
   localparam logic [15:0] IDX_HALT = 16'h605D;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_1 = 8'h01;
   localparam logic [7:0] SUB_2 = 8'h02;

   // ************************************************************
   // Values after reset.
   // ************************************************************
   localparam logic [7:0] COUNT_RST = 8'h02;
   localparam logic signed [31:0] NUM_RST = 32'h00000001;
   localparam logic signed [31:0] DEN_RST = 32'h00000001;
   localparam logic signed [15:0] QS_RST = 16'h0002;
   localparam logic signed [15:0] SD_RST = 16'h0001;
   localparam logic signed [15:0] DIS_RST = 16'h0001;
   localparam logic signed [15:0] HALT_RST = 16'h0001;
   localparam logic [31:0] VQS_DSPEED_RST = 32'h00001388;
   localparam logic [15:0] VQS_DTIME_RST = 16'h0001;

   // ************************************************************
   // Reaction codes and control word fields.
   // ************************************************************
   localparam logic signed [15:0] CODE_IMMED = 16'h0000;
   localparam logic signed [15:0] CODE_SLOW = 16'h0001;
   localparam logic signed [15:0] CODE_QUICK = 16'h0002;
   localparam logic signed [15:0] CODE_SLOW_HOLD = 16'h0005;
   localparam logic signed [15:0] CODE_QUICK_HOLD = 16'h0006;
   localparam int HALT_BIT = 8;

   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_IMMED = 2'h1,
      ACT_SLOW = 2'h2,
      ACT_QUICK = 2'h3
   } srs_act_type;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_STOP = 3'h2,
      ST_HOLD = 3'h4
   } srs_state_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } srs_obj_req_type;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } srs_obj_rsp_type;

   typedef struct packed {
      logic [31:0] dspeed;
      logic [15:0] dtime;
   } srs_ramp_type;

endpackage

// *** verilog/srs_div.sv ***
`timescale 1ns/1ps

// Signed iterative divider, one quotient bit per clock.
module srs_div #(
   parameter int NW = 64,
   parameter int DW = 32
) (
   input wire logic clock_i,                 // Clock.
   input wire logic rstn_i,                  // Async reset, low.
   input wire logic start_i,                 // Start pulse.
   input wire logic signed [NW-1:0] num_i,   // Dividend.
   input wire logic signed [DW-1:0] den_i,   // Divisor.
   output logic done_o,                      // Result pulse.
   output logic dz_o,                        // Divisor was zero.
   output logic signed [NW-1:0] quo_o        // Quotient.
);

   logic [DW:0] rem_q;
   logic [NW-1:0] quo_q;
   logic [DW-1:0] den_q;
   logic neg_q;
   logic run_q;
   logic [7:0] cnt_q;
   logic [DW:0] rem_sh;
   logic [DW:0] diff;
   logic [NW-1:0] num_mag;
   logic [DW-1:0] den_mag;
   logic last;

   // ************************************************************
   // Magnitudes and one restoring step.
   // ************************************************************
   assign num_mag = num_i[NW-1] ? NW'(-num_i) : NW'(num_i);
   assign den_mag = den_i[DW-1] ? DW'(-den_i) : DW'(den_i);
   assign rem_sh = {rem_q[DW-1:0], quo_q[NW-1]};
   assign diff = rem_sh - {1'b0, den_q};
   assign last = (cnt_q == 8'(NW - 1));

   // Sequencer; a zero divisor finishes at once with a zero result.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rem_q <= '0;
         quo_q <= '0;
         den_q <= '0;
         neg_q <= 1'b0;
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         done_o <= 1'b0;
         dz_o <= 1'b0;
         quo_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !run_q) begin
            rem_q <= '0;
            quo_q <= num_mag;
            den_q <= den_mag;
            neg_q <= num_i[NW-1] ^ den_i[DW-1];
            cnt_q <= 8'h00;
            run_q <= (den_i != '0);
            done_o <= (den_i == '0);
            dz_o <= (den_i == '0);
            if (den_i == '0) begin
               quo_o <= '0;
            end
         end else if (run_q) begin
            rem_q <= diff[DW] ? rem_sh : diff;
            quo_q <= {quo_q[NW-2:0], ~diff[DW]};
            cnt_q <= cnt_q + 8'h01;
            if (last) begin
               run_q <= 1'b0;
               done_o <= 1'b1;
               quo_o <= neg_q ? NW'(-{quo_q[NW-2:0], ~diff[DW]})
                              : NW'({quo_q[NW-2:0], ~diff[DW]});
            end
         end
      end
   end

endmodule

// *** verif/srs_stop_reaction_chk.sv ***
`timescale 1ns/1ps

// ********
// Port checker.
// ********
module srs_stop_reaction_chk (
   input wire logic clock_i, // Clock.
   input wire logic rstn_i, // Reset, low.
   input wire srs_pkg::srs_obj_req_type obj_req_i, // Request.
   input wire srs_pkg::srs_obj_rsp_type obj_rsp_o, // Answer.
   input wire logic quick_stop_evt_i, // Quick stop.
   input wire logic shutdown_evt_i, // Shutdown.
   input wire logic disable_evt_i, // Disable.
   input wire logic [15:0] control_word_i, // Control word.
   input wire logic operation_enable_i, // Leave hold.
   input wire srs_pkg::srs_act_type stop_action_o, // Action.
   input wire logic to_switch_on_disabled_o, // State pulse.
   input wire logic quick_stop_hold_o, // Hold.
   input wire logic stop_busy_o, // Stop busy.
   input wire logic speed_valid_i, // Sample.
   input wire logic speed_busy_o, // Conversion busy.
   input wire logic speed_rpm_valid_o // Result pulse.
);
   // Sequencer idle and no event pending.
   wire idle = !stop_busy_o && !quick_stop_hold_o;
   wire no_evt = !(quick_stop_evt_i || shutdown_evt_i || disable_evt_i);

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   // Properties.
   property p_ack;
      obj_req_i.wr || obj_req_i.rd |=> obj_rsp_o.ack;
   endproperty
   a_ack: assert property (p_ack) else $error("No answer.");
   property p_start;
      quick_stop_evt_i && idle |=> stop_busy_o && stop_action_o != 2'h0;
   endproperty
   a_start: assert property (p_start) else $error("No stop.");
   property p_immed;
      stop_action_o == 2'h1 && stop_busy_o |=>
         stop_action_o == 2'h0 && to_switch_on_disabled_o;
   endproperty
   a_immed: assert property (p_immed) else $error("Long stop.");
   property p_sod;
      to_switch_on_disabled_o |=> !to_switch_on_disabled_o;
   endproperty
   a_sod: assert property (p_sod) else $error("Long pulse.");
   property p_hold_rise;
      $rose(quick_stop_hold_o) |-> !to_switch_on_disabled_o && $past(stop_busy_o);
   endproperty
   a_hold_rise: assert property (p_hold_rise) else $error("Bad hold.");
   property p_hold_exit;
      quick_stop_hold_o && operation_enable_i |=> !quick_stop_hold_o;
   endproperty
   a_hold_exit: assert property (p_hold_exit) else $error("Stuck.");
   property p_halt_off;
      !control_word_i[8] && idle && no_evt |=> stop_action_o == 2'h0;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("Halt on.");
   property p_speed;
      speed_valid_i && !speed_busy_o |-> ##[3:66] speed_rpm_valid_o;
   endproperty
   a_speed: assert property (p_speed) else $error("No result.");
endmodule

// *** verif/srs_master_model.sv ***
`timescale 1ns/1ps

// ********
// Fieldbus master that reads and writes the drive objects.
// ********
module srs_master_model (
   input wire logic clock_i, // Clock.
   output srs_pkg::srs_obj_req_type req_o, // Object request.
   input wire srs_pkg::srs_obj_rsp_type rsp_i // Object answer.
);
   // Quiet until the first access.
   initial req_o = '0;

   // Strobe after gap + 1 edges, so back to back calls never
   // drive req_o twice at once; released lines invert.
   task automatic access(input logic w, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] d, input int gap,
      output srs_pkg::srs_obj_rsp_type got);
      repeat (gap + 1) @(negedge clock_i);
      req_o = '{w, !w, idx, sub, d};
      @(negedge clock_i);
      req_o = '{1'b0, 1'b0, ~idx, ~sub, ~d};
      got = rsp_i;
   endtask
endmodule

// *** verif/srs_stop_reaction_tb_top.sv ***
`timescale 1ns/1ps

`define CHK(n, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   end \
end

bind srs_stop_reaction srs_stop_reaction_chk i_chk (.*);

module srs_stop_reaction_tb_top;
   typedef struct packed {
      logic wr;
      logic [15:0] idx;
      logic [7:0] sub;
      logic [31:0] d;
      logic err;
   } srs_row_type;
   typedef struct packed {
      logic [1:0] evt;
      logic [15:0] code;
      logic vel;
      logic [1:0] act;
      logic hold;
   } srs_stop_type;
   localparam srs_pkg::srs_ramp_type SLOW = '{32'h00000300, 16'h0004};
   localparam srs_pkg::srs_ramp_type MQS = '{32'h00000900, 16'h0002};
   localparam srs_pkg::srs_ramp_type VQS = '{srs_pkg::VQS_DSPEED_RST,
      srs_pkg::VQS_DTIME_RST};
   // Object rows; reads expect d.
   localparam srs_row_type OBJ [16] = '{
      '{1'b0, 16'h605A, 8'h00, 32'h00000002, 1'b0},
      '{1'b0, 16'h605B, 8'h00, 32'h00000001, 1'b0},
      '{1'b0, 16'h605C, 8'h00, 32'h00000001, 1'b0},
      '{1'b0, 16'h605D, 8'h00, 32'h00000001, 1'b0},
      '{1'b0, 16'h604C, 8'h00, 32'h00000002, 1'b0},
      '{1'b0, 16'h604C, 8'h01, 32'h00000001, 1'b0},
      '{1'b0, 16'h604C, 8'h02, 32'h00000001, 1'b0},
      '{1'b0, 16'h604A, 8'h01, 32'h00001388, 1'b0},
      '{1'b1, 16'h604C, 8'h00, 32'h00000005, 1'b1},
      '{1'b0, 16'h6060, 8'h00, 32'h00000000, 1'b1},
      '{1'b1, 16'h605A, 8'h00, 32'h00000003, 1'b1},
      '{1'b1, 16'h605B, 8'h00, 32'h00000002, 1'b1},
      '{1'b1, 16'h605C, 8'h00, 32'h0000FFFF, 1'b1},
      '{1'b1, 16'h605D, 8'h00, 32'h00000000, 1'b1},
      '{1'b0, 16'h605A, 8'h00, 32'h00000002, 1'b0},
      '{1'b0, 16'h605D, 8'h00, 32'h00000001, 1'b0}};
   // Event, code, vel, action, hold.
   localparam srs_stop_type STOPS [10] = '{
      '{2'h0, 16'h0000, 1'b1, 2'h1, 1'b0},
      '{2'h0, 16'h0001, 1'b1, 2'h2, 1'b0},
      '{2'h0, 16'h0002, 1'b1, 2'h3, 1'b0},
      '{2'h0, 16'h0002, 1'b0, 2'h3, 1'b0},
      '{2'h0, 16'h0005, 1'b1, 2'h2, 1'b1},
      '{2'h0, 16'h0006, 1'b1, 2'h3, 1'b1},
      '{2'h1, 16'h0000, 1'b1, 2'h1, 1'b0},
      '{2'h1, 16'h0001, 1'b1, 2'h2, 1'b0},
      '{2'h2, 16'h0000, 1'b1, 2'h1, 1'b0},
      '{2'h2, 16'h0001, 1'b1, 2'h2, 1'b0}};
   logic clock_i;
   logic rstn_i;
   srs_pkg::srs_obj_req_type req;
   srs_pkg::srs_obj_rsp_type rsp;
   srs_pkg::srs_obj_rsp_type g;
   srs_pkg::srs_act_type act;
   srs_pkg::srs_ramp_type ramp;
   logic qs, sd, dis, op_en, still, vel, sv, sod, hold, busy, rv, sbusy, dz;
   logic [15:0] cw;
   logic signed [31:0] spd, rpm;
   int num_errors = 0;
   int tests_run = 0;

   srs_stop_reaction i_dut (.clock_i, .rstn_i, .obj_req_i(req),
      .obj_rsp_o(rsp), .quick_stop_evt_i(qs), .shutdown_evt_i(sd),
      .disable_evt_i(dis), .control_word_i(cw), .operation_enable_i(op_en),
      .standstill_i(still), .velocity_mode_i(vel), .slow_ramp_i(SLOW),
      .mode_qs_ramp_i(MQS), .stop_action_o(act), .ramp_o(ramp),
      .to_switch_on_disabled_o(sod), .quick_stop_hold_o(hold),
      .stop_busy_o(busy), .speed_valid_i(sv), .speed_int_i(spd),
      .speed_rpm_o(rpm), .speed_rpm_valid_o(rv), .speed_busy_o(sbusy),
      .speed_div_zero_o(dz));
   srs_master_model i_master (.clock_i, .req_o(req), .rsp_i(rsp));

   // Free-running 250 MHz clock.
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // Expected ramp.
   function automatic srs_pkg::srs_ramp_type exp_ramp(input logic [1:0] a,
      input logic v);
      if (a == 2'h2) return SLOW;
      if (a == 2'h3) return v ? VQS : MQS;
      return '0;
   endfunction

   // One stop case.
   task automatic stop_case(input srs_stop_type s);
      int n;
      i_master.access(1'b1, 16'h605A + 16'(s.evt), 8'h00, {16'h0, s.code},
         0, g);
      vel = s.vel;
      {dis, sd, qs} = 3'b001 << s.evt;
      @(negedge clock_i);
      {dis, sd, qs} = 3'b000;
      `CHK("action", s.act, act);
      `CHK("ramp", exp_ramp(s.act, s.vel), ramp);
      if (s.act != 2'h1) begin
         repeat (2) @(negedge clock_i);
         `CHK("early end", 1'b0, sod | hold);
         still = 1'b1;
      end
      n = 0;
      while (sod !== 1'b1 && hold !== 1'b1 && n < 4) begin
         @(negedge clock_i);
         n++;
      end
      still = 1'b0;
      `CHK("hold", s.hold, hold);
      `CHK("sod", !s.hold, sod);
      op_en = s.hold;
      @(negedge clock_i);
      op_en = 1'b0;
      `CHK("hold exit", 1'b0, hold);
   endtask

   // One speed case.
   task automatic speed_case(input logic [31:0] v, input logic [31:0] e,
      input logic ez);
      int n;
      spd = v;
      sv = 1'b1;
      @(negedge clock_i);
      sv = 1'b0;
      n = 0;
      while (rv !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      `CHK("rpm", e, rpm);
      `CHK("div zero", ez, dz);
   endtask

   // Verdict.
   task automatic complete_run;
      $display("COUNTS tests_run %0d num_errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog.
   initial begin
      #(5000 * 4);
      num_errors++;
      $display("TEST watchdog expired");
      complete_run;
   end

   // Main sequence.
   initial begin
      {qs, sd, dis, op_en, still, vel, sv} = '0;
      cw = 16'h0000;
      spd = 32'h00000000;
      rstn_i = 1'b0;
      repeat (5) @(negedge clock_i);
      `CHK("reset busy", 1'b0, busy);
      rstn_i = 1'b1;
      foreach (OBJ[i]) begin
         i_master.access(OBJ[i].wr, OBJ[i].idx, OBJ[i].sub, OBJ[i].d, i % 2, g);
         `CHK("ack", 1'b1, g.ack);
         `CHK("err", OBJ[i].err, g.err);
         if (!OBJ[i].wr && !OBJ[i].err) begin
            `CHK("rdata", OBJ[i].d, g.rdata);
         end
      end
      $display("TEST objects done");
      foreach (STOPS[i]) stop_case(STOPS[i]);
      $display("TEST stops done");
      for (int c = 1; c <= 2; c++) begin
         i_master.access(1'b1, 16'h605D, 8'h00, 32'(c), 0, g);
         cw = 16'h0100;
         repeat (2) @(negedge clock_i);
         `CHK("halt", 2'(c + 1), act);
         `CHK("halt sod", 1'b0, sod);
         cw = 16'h0000;
         repeat (2) @(negedge clock_i);
      end
      $display("TEST halt done");
      speed_case(32'h00012345, 32'h00012345, 1'b0);
      i_master.access(1'b1, 16'h604C, 8'h01, 32'h0000003C, 0, g);
      i_master.access(1'b1, 16'h604C, 8'h02, 32'hFFFFFFF9, 0, g);
      speed_case(32'h00000064, 32'hFFFFFCA7, 1'b0);
      i_master.access(1'b1, 16'h604C, 8'h02, 32'h00000000, 0, g);
      speed_case(32'h00000005, 32'h00000000, 1'b1);
      $display("TEST speed done");
      rstn_i = 1'b0;
      @(negedge clock_i);
      `CHK("mid reset", 2'h0, act);
      rstn_i = 1'b1;
      i_master.access(1'b0, 16'h605A, 8'h00, 32'h00000000, 0, g);
      `CHK("code preset", 32'h00000002, g.rdata);
      $display("TEST reset done");
      complete_run;
   end
endmodule
